// File: shared/hostport_pkg.sv
// constants shared by the host port and status pin logic
package hostport_pkg;

    // number of monitored clock inputs, one loss flag each
    localparam int NUM_CLK_INPUTS = 3;
    // status vector width: lock bit above the input bits
    localparam int STATUS_W = NUM_CLK_INPUTS + 1;
    localparam int STAT_LOCK_BIT = 3;

    // register index width and register indices
    localparam int REG_IDX_W = 7;
    localparam logic [6:0] REG_STATUS = 7'h00;
    localparam logic [6:0] REG_FLAGS = 7'h01;
    localparam logic [6:0] REG_IRQ_MASK = 7'h02;
    localparam logic [6:0] REG_CONFIG = 7'h03;
    localparam logic [6:0] REG_OUT_ENABLE = 7'h04;

    // reset values
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h0f;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] OUT_ENABLE_RESET = 8'hff;

    // config register field: three-wire spi data on the data pin
    localparam int CFG_THREE_WIRE_BIT = 0;

    // i2c address: fixed upper five bits, straps give the low two
    localparam logic [4:0] I2C_ADDR_BASE = 5'h1a;
    // spi command byte: top bit high means read
    localparam int SPI_RW_BIT = 7;
    // bits in a serial byte
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    // synchronised pin vector layout
    localparam int PIN_W = 7;
    localparam int PIN_HARD_RESET_N = 6;
    localparam int PIN_OUT_DISABLE = 5;
    localparam int PIN_SCLK = 4;
    localparam int PIN_SDATA = 3;
    localparam int PIN_ADDR1 = 2;
    localparam int PIN_ADDR0_SEL_N = 1;
    localparam int PIN_I2C_MODE = 0;
    // idle pin levels; reset pin starts low so status settles first
    localparam logic [6:0] PIN_IDLE = 7'h1b;

endpackage

// File: hdl/hostport_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module hostport_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1; // metastable catcher, read by stage2 only
    logic [WIDTH-1:0] stage2; // first settled copy
    logic [WIDTH-1:0] stage3; // second settled copy
    logic [WIDTH-1:0] next_sync; // filtered level

    // a bit moves only once stages two and three agree
    assign next_sync = (stage2 & stage3) | (sync_out & (stage2 ^ stage3));

    // shift chain and filtered output
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            sync_out <= next_sync;
        end
    end

endmodule

// File: hdl/hostport_status.sv
// serial host port (i2c or spi) and status pin logic
//
// Contract
// - i2c: shared pin is address bit one strap
// - four-wire spi: read data on shared pin
// - one serial clock pin for both modes
// - i2c: select pin is address bit zero
// - spi: respond only while select is low
// - irq output low after status change
// - hard reset low resets all logic (here engine idles, registers reload; ptr and lock/loss outputs keep running)
// - output disable high turns outputs off
// - lock indicator high locked, low unlocked
// - per-input loss output low without clock
// - mode pin one i2c, zero spi
// - data pin two-way except four-wire spi
`timescale 1ns/100ps
module hostport_status #(
    parameter int NUM_OUTS = 8 // clock outputs, at most eight
) (
    input wire logic CORE_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic HARD_RESET_N_IN,
    input wire logic OUTPUT_DISABLE_IN,
    input wire logic I2C_MODE_SEL_IN,
    input wire logic SERIAL_CLK_IN,
    input wire logic SERIAL_DATA_IN,
    output logic SERIAL_DATA_OUT,
    output logic SERIAL_DATA_OE_OUT,
    input wire logic ADDR_BIT1_OR_SERIAL_OUT_IN,
    output logic ADDR_BIT1_OR_SERIAL_OUT_OUT,
    output logic ADDR_BIT1_OR_SERIAL_OUT_OE_OUT,
    input wire logic ADDR_BIT0_OR_SELECT_N_IN,
    input wire logic PLL_LOCKED_IN,
    input wire logic [hostport_pkg::NUM_CLK_INPUTS-1:0] CLOCK_PRESENT_IN,
    output logic STATUS_CHANGE_IRQ_N_OUT,
    output logic LOCK_LOST_N_OUT,
    output logic INPUT0_SIGNAL_LOST_N_OUT,
    output logic INPUT1_SIGNAL_LOST_N_OUT,
    output logic INPUT2_SIGNAL_LOST_N_OUT,
    output logic [NUM_OUTS-1:0] CLOCK_OUT_ENABLE_OUT
);

    // serial engine states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_RD_ACK,
        ST_SPI_CMD,
        ST_SPI_WR,
        ST_SPI_RD
    } engine_state_t;

    // filtered pins
    logic [hostport_pkg::PIN_W-1:0] pin_raw; // pins in layout order
    logic [hostport_pkg::PIN_W-1:0] pins; // synchronised levels
    logic soft_rst; // hard reset pin asserted
    logic out_disable; // output disable pin high
    logic i2c_mode; // mode select
    logic scl; // serial clock level
    logic sda; // serial data in level
    logic addr1; // address strap one
    logic sel_n; // address strap zero / chip select
    logic three_wire; // spi data shares the data pin

    // edge and condition detection
    logic scl_q; // previous clock level
    logic sda_q; // previous data level
    logic scl_rise; // serial clock rising
    logic scl_fall; // serial clock falling
    logic i2c_start; // data falls with clock high
    logic i2c_stop; // data rises with clock high
    logic addr_hit; // received address is ours
    logic [7:0] byte_in; // shift register plus current bit
    logic [7:0] rd_data; // register read at pointer

    // engine registers
    engine_state_t state; // engine state
    engine_state_t ret; // state after an acknowledge
    logic [3:0] cnt; // bits in current byte
    logic [7:0] sh; // shift register
    logic [hostport_pkg::REG_IDX_W-1:0] ptr; // register pointer
    logic ack_ok; // host acknowledged a read byte
    logic dout; // serial data driven out
    logic drive_sda; // enable on the data pin
    logic drive_so; // enable on the shared output pin
    logic wr_en; // register write strobe
    logic [hostport_pkg::REG_IDX_W-1:0] wr_idx; // write index
    logic [7:0] wr_val; // write value

    // register file and status
    logic [hostport_pkg::STATUS_W-1:0] status; // live status
    logic [hostport_pkg::STATUS_W-1:0] status_q; // previous status
    logic [hostport_pkg::STATUS_W-1:0] flags; // sticky change flags
    logic [hostport_pkg::STATUS_W-1:0] flag_set; // changes this cycle
    logic [hostport_pkg::STATUS_W-1:0] flag_clr; // write-one clears
    logic [hostport_pkg::STATUS_W-1:0] next_flags; // updated flags
    logic [7:0] irq_mask; // enables flags onto irq
    logic [7:0] config_reg; // mode options
    logic [7:0] out_enable; // per-output enables
    logic [hostport_pkg::NUM_CLK_INPUTS-1:0] present_q; // input seen

    // pins passed through the three-stage filter
    assign pin_raw = {HARD_RESET_N_IN, OUTPUT_DISABLE_IN, SERIAL_CLK_IN,
        SERIAL_DATA_IN, ADDR_BIT1_OR_SERIAL_OUT_IN,
        ADDR_BIT0_OR_SELECT_N_IN, I2C_MODE_SEL_IN};

    // synchroniser for every host port and control pin; lock and presence inputs bypass it
    hostport_sync #(
        .WIDTH(hostport_pkg::PIN_W),
        .RESET_VAL(hostport_pkg::PIN_IDLE)
    ) u_pin_sync (
        .clk_in(CORE_CLK_IN),
        .resetn_in(RESETN_IN),
        .async_in(pin_raw),
        .sync_out(pins)
    );

    // pin decode
    assign soft_rst = ~pins[hostport_pkg::PIN_HARD_RESET_N];
    assign out_disable = pins[hostport_pkg::PIN_OUT_DISABLE];
    assign i2c_mode = pins[hostport_pkg::PIN_I2C_MODE];
    assign scl = pins[hostport_pkg::PIN_SCLK];
    assign sda = pins[hostport_pkg::PIN_SDATA];
    assign addr1 = pins[hostport_pkg::PIN_ADDR1];
    assign sel_n = pins[hostport_pkg::PIN_ADDR0_SEL_N];
    assign three_wire = config_reg[hostport_pkg::CFG_THREE_WIRE_BIT];

    // edges of the serial clock and bus conditions
    assign scl_rise = scl & ~scl_q;
    assign scl_fall = ~scl & scl_q;
    assign i2c_start = i2c_mode & scl & scl_q & sda_q & ~sda;
    assign i2c_stop = i2c_mode & scl & scl_q & ~sda_q & sda;
    assign byte_in = {sh[6:0], sda};
    // address straps complete the bus address
    assign addr_hit = (sh[7:1] == {hostport_pkg::I2C_ADDR_BASE, addr1,
        sel_n});

    // register read selection, unmapped reads zero
    assign rd_data =
        (ptr == hostport_pkg::REG_STATUS) ? 8'(status) :
        (ptr == hostport_pkg::REG_FLAGS) ? 8'(flags) :
        (ptr == hostport_pkg::REG_IRQ_MASK) ? irq_mask :
        (ptr == hostport_pkg::REG_CONFIG) ? config_reg :
        (ptr == hostport_pkg::REG_OUT_ENABLE) ? out_enable : 8'h00;

    // status and flag update, set wins over clear
    assign status = {PLL_LOCKED_IN, CLOCK_PRESENT_IN};
    assign flag_set = status ^ status_q;
    assign flag_clr = (wr_en && wr_idx == hostport_pkg::REG_FLAGS) ?
        wr_val[hostport_pkg::STATUS_W-1:0] : '0;
    assign next_flags = (flags & ~flag_clr) | flag_set;

    // previous serial levels for edge detection
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    // serial protocol engine for both bus modes
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state <= ST_IDLE;
            ret <= ST_IDLE;
            cnt <= 4'h0;
            sh <= 8'h00;
            ptr <= '0;
            ack_ok <= 1'b0;
            dout <= 1'b0;
            drive_sda <= 1'b0;
            drive_so <= 1'b0;
            wr_en <= 1'b0;
            wr_idx <= '0;
            wr_val <= 8'h00;
        end else if (soft_rst) begin
            // hard reset pin idles the engine
            state <= ST_IDLE;
            cnt <= 4'h0;
            dout <= 1'b0;
            drive_sda <= 1'b0;
            drive_so <= 1'b0;
            wr_en <= 1'b0;
        end else if (i2c_mode) begin
            wr_en <= 1'b0;
            dout <= 1'b0; // open drain: only ever pulls low
            drive_so <= 1'b0; // shared pin stays a strap input
            if (i2c_start) begin
                // start or repeated start
                state <= ST_ADDR;
                cnt <= 4'h0;
                drive_sda <= 1'b0;
            end else if (i2c_stop) begin
                state <= ST_IDLE;
                drive_sda <= 1'b0;
            end else begin
                case (state)
                    ST_ADDR, ST_PTR, ST_WDATA: begin
                        if (scl_rise) begin
                            // shift a received bit in
                            sh <= byte_in;
                            cnt <= cnt + 4'h1;
                        end else if (scl_fall &&
                                cnt == hostport_pkg::BYTE_BITS) begin
                            cnt <= 4'h0;
                            drive_sda <= 1'b1; // acknowledge low
                            state <= ST_ACK;
                            if (state == ST_ADDR) begin
                                // address byte, ignore other devices
                                ret <= sh[0] ? ST_RDATA : ST_PTR;
                                if (!addr_hit) begin
                                    drive_sda <= 1'b0;
                                    state <= ST_IDLE;
                                end
                            end else if (state == ST_PTR) begin
                                ptr <= sh[6:0];
                                ret <= ST_WDATA;
                            end else begin
                                // data byte, pointer advances
                                wr_en <= 1'b1;
                                wr_idx <= ptr;
                                wr_val <= sh;
                                ptr <= ptr + 7'h01;
                                ret <= ST_WDATA;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            // end of acknowledge clock
                            state <= ret;
                            drive_sda <= 1'b0;
                            if (ret == ST_RDATA) begin
                                sh <= rd_data;
                                ptr <= ptr + 7'h01;
                                drive_sda <= ~rd_data[7];
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (scl_rise) begin
                            cnt <= cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (cnt == hostport_pkg::BYTE_BITS) begin
                                // release for host acknowledge
                                cnt <= 4'h0;
                                drive_sda <= 1'b0;
                                state <= ST_RD_ACK;
                            end else begin
                                sh <= {sh[6:0], 1'b0};
                                drive_sda <= ~sh[6];
                            end
                        end
                    end
                    ST_RD_ACK: begin
                        if (scl_rise) begin
                            ack_ok <= ~sda;
                        end else if (scl_fall) begin
                            if (ack_ok) begin
                                // host wants another byte
                                sh <= rd_data;
                                ptr <= ptr + 7'h01;
                                drive_sda <= ~rd_data[7];
                                state <= ST_RDATA;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        drive_sda <= 1'b0;
                    end
                endcase
            end
        end else if (sel_n) begin
            // spi deselected: quiet and idle
            state <= ST_IDLE;
            wr_en <= 1'b0;
            drive_sda <= 1'b0;
            drive_so <= 1'b0;
        end else begin
            wr_en <= 1'b0;
            case (state)
                ST_SPI_CMD: begin
                    if (scl_rise) begin
                        // command byte: direction and index
                        sh <= byte_in;
                        cnt <= cnt + 4'h1;
                        if (cnt == hostport_pkg::LAST_BIT) begin
                            cnt <= 4'h0;
                            ptr <= byte_in[6:0];
                            state <= byte_in[hostport_pkg::SPI_RW_BIT] ?
                                ST_SPI_RD : ST_SPI_WR;
                        end
                    end
                end
                ST_SPI_WR: begin
                    if (scl_rise) begin
                        sh <= byte_in;
                        cnt <= cnt + 4'h1;
                        if (cnt == hostport_pkg::LAST_BIT) begin
                            // streaming write with increment
                            cnt <= 4'h0;
                            wr_en <= 1'b1;
                            wr_idx <= ptr;
                            wr_val <= byte_in;
                            ptr <= ptr + 7'h01;
                        end
                    end
                end
                ST_SPI_RD: begin
                    if (scl_rise) begin
                        cnt <= (cnt == hostport_pkg::LAST_BIT) ?
                            4'h0 : cnt + 4'h1;
                    end else if (scl_fall) begin
                        drive_sda <= three_wire;
                        drive_so <= ~three_wire;
                        if (cnt == 4'h0) begin
                            sh <= rd_data;
                            dout <= rd_data[7];
                            ptr <= ptr + 7'h01;
                        end else begin
                            sh <= {sh[6:0], 1'b0};
                            dout <= sh[6];
                        end
                    end
                end
                default: begin
                    // select just went low
                    state <= ST_SPI_CMD;
                    cnt <= 4'h0;
                    drive_sda <= 1'b0;
                    drive_so <= 1'b0;
                end
            endcase
        end
    end

    // register file, flags and previous status
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            status_q <= '0;
            flags <= hostport_pkg::FLAGS_RESET[hostport_pkg::STATUS_W-1:0];
            irq_mask <= hostport_pkg::IRQ_MASK_RESET;
            config_reg <= hostport_pkg::CONFIG_RESET;
            out_enable <= hostport_pkg::OUT_ENABLE_RESET;
        end else if (soft_rst) begin
            // defaults restored while reset pin low
            status_q <= status;
            flags <= hostport_pkg::FLAGS_RESET[hostport_pkg::STATUS_W-1:0];
            irq_mask <= hostport_pkg::IRQ_MASK_RESET;
            config_reg <= hostport_pkg::CONFIG_RESET;
            out_enable <= hostport_pkg::OUT_ENABLE_RESET;
        end else begin
            status_q <= status;
            flags <= next_flags;
            if (wr_en && wr_idx == hostport_pkg::REG_IRQ_MASK) begin
                irq_mask <= wr_val;
            end
            if (wr_en && wr_idx == hostport_pkg::REG_CONFIG) begin
                config_reg <= wr_val;
            end
            if (wr_en && wr_idx == hostport_pkg::REG_OUT_ENABLE) begin
                out_enable <= wr_val;
            end
        end
    end

    // pin outputs, all from flip-flops
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            STATUS_CHANGE_IRQ_N_OUT <= 1'b1;
            LOCK_LOST_N_OUT <= 1'b0;
            present_q <= '0;
            CLOCK_OUT_ENABLE_OUT <= '0;
        end else begin
            // low while any unmasked flag stands
            STATUS_CHANGE_IRQ_N_OUT <=
                ~|(flags & irq_mask[hostport_pkg::STATUS_W-1:0]);
            LOCK_LOST_N_OUT <= PLL_LOCKED_IN;
            present_q <= CLOCK_PRESENT_IN;
            // outputs off in reset or while disabled
            CLOCK_OUT_ENABLE_OUT <= (soft_rst || out_disable) ? '0 :
                out_enable[NUM_OUTS-1:0];
        end
    end

    // per-input loss outputs
    assign INPUT0_SIGNAL_LOST_N_OUT = present_q[0];
    assign INPUT1_SIGNAL_LOST_N_OUT = present_q[1];
    assign INPUT2_SIGNAL_LOST_N_OUT = present_q[2];

    // serial data outputs
    assign SERIAL_DATA_OUT = dout;
    assign SERIAL_DATA_OE_OUT = drive_sda;
    assign ADDR_BIT1_OR_SERIAL_OUT_OUT = dout;
    assign ADDR_BIT1_OR_SERIAL_OUT_OE_OUT = drive_so;

endmodule

// File: verification/hostport_status_props.sv
// assertions on the host port and status pins
`timescale 1ns/100ps
module hostport_status_props #(
    parameter int NUM_OUTS = 8
) (
    input wire logic CORE_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic HARD_RESET_N_IN,
    input wire logic OUTPUT_DISABLE_IN,
    input wire logic I2C_MODE_SEL_IN,
    input wire logic ADDR_BIT0_OR_SELECT_N_IN,
    input wire logic PLL_LOCKED_IN,
    input wire logic [hostport_pkg::NUM_CLK_INPUTS-1:0] CLOCK_PRESENT_IN,
    input wire logic SERIAL_DATA_OUT,
    input wire logic SERIAL_DATA_OE_OUT,
    input wire logic ADDR_BIT1_OR_SERIAL_OUT_OE_OUT,
    input wire logic STATUS_CHANGE_IRQ_N_OUT,
    input wire logic LOCK_LOST_N_OUT,
    input wire logic INPUT0_SIGNAL_LOST_N_OUT,
    input wire logic INPUT1_SIGNAL_LOST_N_OUT,
    input wire logic INPUT2_SIGNAL_LOST_N_OUT,
    input wire logic [NUM_OUTS-1:0] CLOCK_OUT_ENABLE_OUT
);
    // single core clock domain
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    // loss pins in input order
    wire [2:0] lost_n = {INPUT2_SIGNAL_LOST_N_OUT,
        INPUT1_SIGNAL_LOST_N_OUT, INPUT0_SIGNAL_LOST_N_OUT};
    wire a1_oe = ADDR_BIT1_OR_SERIAL_OUT_OE_OUT;
    // spi mode with select high
    wire spi_idle = !I2C_MODE_SEL_IN && ADDR_BIT0_OR_SELECT_N_IN;
    lock_follow_a: assert property (
        $past(RESETN_IN) |-> LOCK_LOST_N_OUT == $past(PLL_LOCKED_IN))
        else $error("lock pin lags lock input");
    loss_follow_a: assert property (
        $past(RESETN_IN) |-> lost_n == $past(CLOCK_PRESENT_IN))
        else $error("loss pins lag presence inputs");
    out_disable_a: assert property (
        OUTPUT_DISABLE_IN [*8] |=> CLOCK_OUT_ENABLE_OUT == '0)
        else $error("outputs on while disabled");
    hard_reset_a: assert property (
        !HARD_RESET_N_IN [*8] |=> CLOCK_OUT_ENABLE_OUT == '0
        && STATUS_CHANGE_IRQ_N_OUT && !SERIAL_DATA_OE_OUT && !a1_oe)
        else $error("state not cleared in hard reset");
    spi_quiet_a: assert property (
        spi_idle [*8] |=> !SERIAL_DATA_OE_OUT && !a1_oe)
        else $error("pin driven while deselected");
    strap_only_a: assert property (
        I2C_MODE_SEL_IN [*8] |=> !a1_oe)
        else $error("strap pin driven in i2c mode");
    drain_only_a: assert property (
        I2C_MODE_SEL_IN [*8] |=> !SERIAL_DATA_OUT)
        else $error("data pin driven high in i2c mode");
    one_driver_a: assert property (
        a1_oe |-> !SERIAL_DATA_OE_OUT)
        else $error("both data pins driven");
    // main scenarios reached
    cover property (a1_oe);
    cover property (SERIAL_DATA_OE_OUT);
    cover property ($fell(STATUS_CHANGE_IRQ_N_OUT));
endmodule
bind hostport_status hostport_status_props #(.NUM_OUTS(NUM_OUTS)) u_props (
    .CORE_CLK_IN(CORE_CLK_IN), .RESETN_IN(RESETN_IN),
    .HARD_RESET_N_IN(HARD_RESET_N_IN), .OUTPUT_DISABLE_IN(OUTPUT_DISABLE_IN),
    .I2C_MODE_SEL_IN(I2C_MODE_SEL_IN), .PLL_LOCKED_IN(PLL_LOCKED_IN),
    .ADDR_BIT0_OR_SELECT_N_IN(ADDR_BIT0_OR_SELECT_N_IN),
    .CLOCK_PRESENT_IN(CLOCK_PRESENT_IN), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
    .SERIAL_DATA_OE_OUT(SERIAL_DATA_OE_OUT),
    .ADDR_BIT1_OR_SERIAL_OUT_OE_OUT(ADDR_BIT1_OR_SERIAL_OUT_OE_OUT),
    .STATUS_CHANGE_IRQ_N_OUT(STATUS_CHANGE_IRQ_N_OUT),
    .LOCK_LOST_N_OUT(LOCK_LOST_N_OUT),
    .INPUT0_SIGNAL_LOST_N_OUT(INPUT0_SIGNAL_LOST_N_OUT),
    .INPUT1_SIGNAL_LOST_N_OUT(INPUT1_SIGNAL_LOST_N_OUT),
    .INPUT2_SIGNAL_LOST_N_OUT(INPUT2_SIGNAL_LOST_N_OUT),
    .CLOCK_OUT_ENABLE_OUT(CLOCK_OUT_ENABLE_OUT));

// File: verification/spi_host_model.sv
// spi host controller model, mode 0, 80 ns serial clock
`timescale 1ns/100ps
module spi_host_model (
    input wire logic clk,
    input wire logic so_in, // four-wire read data
    input wire logic sd_in, // resolved data pin
    output logic sclk,
    output logic cs_n,
    output logic sd_out
);
    logic three_wire = 1'b0; // read on data pin
    // idle: clock still low, deselected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sd_out = 1'b0;
    end
    // half serial period in core cycles
    task automatic half();
        repeat (10) @(negedge clk);
    endtask
    // one byte msb first; released line toggles
    task automatic byte_io(input logic [7:0] tx, input logic drv,
                           output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sd_out = drv ? tx[i] : ~sd_out;
            half();
            rx[i] = three_wire ? sd_in : so_in;
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
    endtask
    // framed command byte plus one data byte
    task automatic xfer(input logic rd, input logic [6:0] idx,
                        input logic [7:0] wd, output logic [7:0] rdat);
        logic [7:0] junk;
        cs_n = 1'b0;
        half();
        byte_io({rd, idx}, 1'b1, junk);
        byte_io(wd, !(rd && three_wire), rdat);
        half();
        cs_n = 1'b1;
        sd_out = ~sd_out;
        half();
        half();
    endtask
endmodule

// File: verification/hostport_status_tb.sv
// self-checking bench for the host port and status pins
`timescale 1ns/100ps
module hostport_status_tb;
    logic clk = 0, rst_n = 0, hrst_n = 1, odis = 0, i2c = 0, strap1 = 0;
    logic locked = 1;
    logic [2:0] present = 3'h7;
    logic sd_o, sd_oe, a1_o, a1_oe, irq_n, lol_n, l0, l1, l2;
    logic [7:0] en, rd;
    wire sclk, cs_n, host_sd;
    int n_errors = 0, total_checks = 0;
    wire sd_pin = sd_oe ? sd_o : host_sd; // device wins when driving
    wire a1_pin = a1_oe ? a1_o : i2c ? strap1 : ~a1_o; // strap or inverse
    // {lock, present} beside expected {lock_n, loss_n}
    logic [7:0] rows [5] = '{8'h77, 8'h00, 8'h55, 8'haa, 8'hff};
    // {index, reset value}; 0x10 unmapped
    logic [15:0] defs [6] = '{16'h000f, 16'h0100, 16'h020f, 16'h0300,
                              16'h04ff, 16'h1000};
    initial begin
        forever #2 clk = ~clk;
    end
    hostport_status #(.NUM_OUTS(8)) u_dut (
        .CORE_CLK_IN(clk), .RESETN_IN(rst_n), .HARD_RESET_N_IN(hrst_n),
        .OUTPUT_DISABLE_IN(odis), .I2C_MODE_SEL_IN(i2c),
        .SERIAL_CLK_IN(sclk), .SERIAL_DATA_IN(sd_pin),
        .SERIAL_DATA_OUT(sd_o), .SERIAL_DATA_OE_OUT(sd_oe),
        .ADDR_BIT1_OR_SERIAL_OUT_IN(a1_pin),
        .ADDR_BIT1_OR_SERIAL_OUT_OUT(a1_o),
        .ADDR_BIT1_OR_SERIAL_OUT_OE_OUT(a1_oe),
        .ADDR_BIT0_OR_SELECT_N_IN(cs_n), .PLL_LOCKED_IN(locked),
        .CLOCK_PRESENT_IN(present), .STATUS_CHANGE_IRQ_N_OUT(irq_n),
        .LOCK_LOST_N_OUT(lol_n), .INPUT0_SIGNAL_LOST_N_OUT(l0),
        .INPUT1_SIGNAL_LOST_N_OUT(l1), .INPUT2_SIGNAL_LOST_N_OUT(l2),
        .CLOCK_OUT_ENABLE_OUT(en));
    spi_host_model u_host (.clk(clk), .so_in(a1_pin), .sd_in(sd_pin),
        .sclk(sclk), .cs_n(cs_n), .sd_out(host_sd));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd_reg(input logic [6:0] idx, input logic [7:0] exp);
        u_host.xfer(1'b1, idx, 8'h00, rd);
        chk(rd, exp);
    endtask
    task automatic wr_reg(input logic [6:0] idx, input logic [7:0] wd);
        u_host.xfer(1'b0, idx, wd, rd);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog: run needs about 20 us
    initial begin
        #100000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        cyc(6);
        chk({7'h00, irq_n}, 8'h01);
        chk(en, 8'h00);
        cyc(6);
        rst_n = 1;
        cyc(20);
        chk(en, 8'hff);
        foreach (defs[i]) rd_reg(defs[i][14:8],
            defs[i][7:0]);
        $display("test defaults done");
        foreach (rows[i]) begin
            {locked, present} = rows[i][7:4];
            cyc(3);
            chk({4'h0, lol_n, l2, l1, l0},
                {4'h0, rows[i][3:0]});
            chk({7'h00, irq_n}, 8'h00);
        end
        rd_reg(hostport_pkg::REG_STATUS, 8'h0f);
        chk({7'h00, irq_n}, 8'h00);
        wr_reg(hostport_pkg::REG_FLAGS, 8'h0f);
        cyc(4);
        chk({7'h00, irq_n}, 8'h01);
        rd_reg(hostport_pkg::REG_FLAGS, 8'h00);
        $display("test status done");
        wr_reg(hostport_pkg::REG_OUT_ENABLE, 8'h5a);
        chk(en, 8'h5a);
        odis = 1;
        cyc(12);
        chk(en, 8'h00);
        odis = 0;
        cyc(12);
        chk(en, 8'h5a);
        $display("test disable done");
        wr_reg(hostport_pkg::REG_CONFIG, 8'h01);
        u_host.three_wire = 1'b1;
        rd_reg(hostport_pkg::REG_OUT_ENABLE, 8'h5a);
        $display("test three-wire done");
        hrst_n = 0;
        cyc(12);
        chk(en, 8'h00);
        hrst_n = 1;
        u_host.three_wire = 1'b0;
        cyc(12);
        chk(en, 8'hff);
        rd_reg(hostport_pkg::REG_CONFIG, 8'h00);
        $display("test hard reset done");
        i2c = 1;
        strap1 = 1;
        cyc(20);
        chk({6'h00, a1_oe, a1_pin}, 8'h01);
        i2c = 0;
        $display("test i2c strap done");
        cyc(10);
        tally_and_finish();
    end
endmodule
